/* File: rtl/dual_data_space_access.sv */
// Data space access unit: X read/write and Y read paths of the core.
// Assumes the core presents one X and one Y request per cycle.
`default_nettype none
module dual_data_space_access (
  input wire logic clock,
  input wire logic rst,
  input wire logic mac_op,
  input wire logic x_req,
  input wire logic x_write,
  input wire logic x_byte,
  input wire logic x_acc_wb,
  input wire dsa_pkg::addr_mode_e x_mode,
  input wire logic [15:0] x_base,
  input wire logic [15:0] x_direct,
  input wire logic [15:0] x_wdata,
  input wire logic x_ptr_pick,
  input wire logic [15:0] x_pointer_a,
  input wire logic [15:0] x_pointer_b,
  input wire logic y_req,
  input wire dsa_pkg::addr_mode_e y_mode,
  input wire logic y_ptr_pick,
  input wire logic [15:0] y_pointer_a,
  input wire logic [15:0] y_pointer_b,
  input wire logic [15:0] mod_start,
  input wire logic [15:0] mod_end,
  input wire logic [15:0] bitrev_step,
  input wire logic [15:0] dest_old,
  input wire logic [15:0] source_working_reg,
  input wire logic sign_extend_op,
  input wire logic zero_extend_op,
  output logic x_rvalid,
  output logic [15:0] x_rdata,
  output logic [15:0] x_load_value,
  output logic y_rvalid,
  output logic [15:0] y_rdata,
  output logic [15:0] x_next_ptr,
  output logic [15:0] y_next_ptr,
  output logic [15:0] ext_value,
  output logic addr_error
);
  localparam int DW = dsa_pkg::DATA_W;
  localparam int AW = dsa_pkg::ADDR_W;
  localparam int BW = dsa_pkg::BYTE_W;
  localparam int NW = dsa_pkg::NEAR_W;
  localparam int SB = dsa_pkg::BYTE_SEL_BIT;

  logic [AW-1:0] x_src, x_ea, x_step, y_ea;
  logic x_unimpl, x_in_y, x_bad_space, x_misalign;
  logic y_take, y_bad, y_misalign;
  logic [dsa_pkg::LANES-1:0] wr_lane;
  logic [DW-1:0] wr_data, ram_x, ram_y, fmt_read, fmt_load, fmt_ext;

  function automatic logic [15:0] bit_rev(input logic [15:0] v);
    bit_rev = {<<{v}};
  endfunction

  function automatic logic [15:0] post_mod(input logic [15:0] p,
                                           input dsa_pkg::addr_mode_e m,
                                           input logic [15:0] step,
                                           input logic wr);
    logic [15:0] inc;
    logic [15:0] rsum;
    inc = p + step;
    rsum = bit_rev(p) + bit_rev(bitrev_step);
    case (m)
      dsa_pkg::AM_POSTINC: post_mod = inc;
      // Wrap once the pointer reaches the buffer end
      dsa_pkg::AM_MODULO: post_mod = (p >= mod_end) ? mod_start : inc;
      // Reads in bit-reversed mode fall back to a plain step
      dsa_pkg::AM_BITREV: post_mod = wr ? bit_rev(rsum) : inc;
      default: post_mod = p;
    endcase
  endfunction

  // Address generation and access checks
  always_comb begin
    x_src = x_base;
    if (mac_op && !x_acc_wb) begin
      x_src = x_ptr_pick ? x_pointer_b : x_pointer_a;
    end
    x_ea = x_src;
    if (x_mode == dsa_pkg::AM_NEAR) begin
      x_ea = {{(AW-NW){1'h0}}, x_direct[NW-1:0]};
    end else if (x_mode == dsa_pkg::AM_ABS16) begin
      x_ea = x_direct;
    end
    x_step = x_byte ? dsa_pkg::STEP_BYTE : dsa_pkg::STEP_WORD;
    y_ea = y_ptr_pick ? y_pointer_b : y_pointer_a;
    x_unimpl = x_ea >= dsa_pkg::RAM_TOP;
    x_in_y = x_ea >= dsa_pkg::Y_BASE && x_ea <= dsa_pkg::Y_LAST;
    // Only MAC prefetch reads split the space; others see it linear
    x_bad_space = mac_op && !x_acc_wb && !x_write && x_in_y;
    x_misalign = !x_byte && x_ea[SB];
    y_take = y_req && mac_op;
    y_bad = !(y_ea >= dsa_pkg::Y_BASE && y_ea <= dsa_pkg::Y_LAST);
    y_misalign = y_ea[SB];
    wr_lane = dsa_pkg::LANE_NONE;
    // Single write path; accumulator write back may go anywhere below RAM_TOP
    if (x_req && x_write && !x_misalign && !x_unimpl) begin
      wr_lane = dsa_pkg::LANE_BOTH;
      if (x_byte) begin
        wr_lane = x_ea[SB] ? dsa_pkg::LANE_HI : dsa_pkg::LANE_LO;
      end
    end
    wr_data = x_byte ? {x_wdata[BW-1:0], x_wdata[BW-1:0]} : x_wdata;
  end

  data_ram u_ram (
    .clock(clock),
    .rst(rst),
    .wr_lane(wr_lane),
    .wr_addr(x_ea[dsa_pkg::RAM_AW:dsa_pkg::WORD_LSB]),
    .wr_data(wr_data),
    .x_addr(x_ea[dsa_pkg::RAM_AW:dsa_pkg::WORD_LSB]),
    .y_addr(y_ea[dsa_pkg::RAM_AW:dsa_pkg::WORD_LSB]),
    .x_data(ram_x),
    .y_data(ram_y)
  );

  // First stage: request attributes and pointer updates
  logic s1_x_rd, s1_x_byte, s1_x_hi, s1_x_zero, s1_y_rd, s1_y_zero, s1_err;
  logic s1_se, s1_ze;
  logic [DW-1:0] s1_dest, s1_src;
  logic next_s1_x_rd, next_s1_x_byte, next_s1_x_hi, next_s1_x_zero;
  logic next_s1_y_rd, next_s1_y_zero, next_s1_err, next_s1_se, next_s1_ze;
  logic [DW-1:0] next_s1_dest, next_s1_src, next_x_next_ptr, next_y_next_ptr;

  always_comb begin
    next_s1_x_rd = x_req && !x_write;
    next_s1_x_byte = x_byte;
    next_s1_x_hi = x_ea[SB];
    next_s1_x_zero = x_unimpl || x_bad_space;
    next_s1_y_rd = y_take;
    next_s1_y_zero = y_bad;
    next_s1_err = (x_req && x_misalign) || (y_take && y_misalign);
    next_s1_dest = dest_old;
    next_s1_src = source_working_reg;
    next_s1_se = sign_extend_op;
    next_s1_ze = zero_extend_op;
    next_x_next_ptr = x_next_ptr;
    if (x_req) begin
      next_x_next_ptr = post_mod(x_src, x_mode, x_step, x_write);
    end
    next_y_next_ptr = y_next_ptr;
    if (y_take) begin
      next_y_next_ptr = post_mod(y_ea, y_mode, dsa_pkg::STEP_WORD, 1'h0);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_x_rd <= 1'h0;
      s1_x_byte <= 1'h0;
      s1_x_hi <= 1'h0;
      s1_x_zero <= 1'h0;
      s1_y_rd <= 1'h0;
      s1_y_zero <= 1'h0;
      s1_err <= 1'h0;
      s1_dest <= dsa_pkg::ZERO_WORD;
      s1_src <= dsa_pkg::ZERO_WORD;
      s1_se <= 1'h0;
      s1_ze <= 1'h0;
      x_next_ptr <= dsa_pkg::ZERO_WORD;
      y_next_ptr <= dsa_pkg::ZERO_WORD;
    end else begin
      s1_x_rd <= next_s1_x_rd;
      s1_x_byte <= next_s1_x_byte;
      s1_x_hi <= next_s1_x_hi;
      s1_x_zero <= next_s1_x_zero;
      s1_y_rd <= next_s1_y_rd;
      s1_y_zero <= next_s1_y_zero;
      s1_err <= next_s1_err;
      s1_dest <= next_s1_dest;
      s1_src <= next_s1_src;
      s1_se <= next_s1_se;
      s1_ze <= next_s1_ze;
      x_next_ptr <= next_x_next_ptr;
      y_next_ptr <= next_y_next_ptr;
    end
  end

  load_format u_fmt (
    .word(ram_x),
    .byte_hi(s1_x_hi),
    .byte_op(s1_x_byte),
    .zeroed(s1_x_zero),
    .dest_old(s1_dest),
    .source_working_reg(s1_src),
    .sign_extend_op(s1_se),
    .zero_extend_op(s1_ze),
    .read_value(fmt_read),
    .load_value(fmt_load),
    .ext_value(fmt_ext)
  );

  // Output stage: read data, merged load value, error pulse
  logic next_x_rvalid, next_y_rvalid, next_addr_error;
  logic [DW-1:0] next_x_rdata, next_x_load_value, next_y_rdata, next_ext_value;

  always_comb begin
    // A misaligned read still completes; the trap comes in the same cycle
    next_x_rvalid = s1_x_rd;
    next_x_rdata = s1_x_rd ? fmt_read : x_rdata;
    next_x_load_value = s1_x_rd ? fmt_load : x_load_value;
    next_y_rvalid = s1_y_rd;
    next_y_rdata = y_rdata;
    if (s1_y_rd) begin
      next_y_rdata = s1_y_zero ? dsa_pkg::ZERO_WORD : ram_y;
    end
    next_ext_value = (s1_se || s1_ze) ? fmt_ext : ext_value;
    next_addr_error = s1_err;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      x_rvalid <= 1'h0;
      x_rdata <= dsa_pkg::ZERO_WORD;
      x_load_value <= dsa_pkg::ZERO_WORD;
      y_rvalid <= 1'h0;
      y_rdata <= dsa_pkg::ZERO_WORD;
      ext_value <= dsa_pkg::ZERO_WORD;
      addr_error <= 1'h0;
    end else begin
      x_rvalid <= next_x_rvalid;
      x_rdata <= next_x_rdata;
      x_load_value <= next_x_load_value;
      y_rvalid <= next_y_rvalid;
      y_rdata <= next_y_rdata;
      ext_value <= next_ext_value;
      addr_error <= next_addr_error;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_write_only_x;
    (wr_lane != dsa_pkg::LANE_NONE) |-> x_req && x_write;
  endproperty
  a_write_only_x: assert property (p_write_only_x)
    else $error("memory write without an X write request");

  property p_y_needs_mac;
    y_req && !mac_op |-> ##2 !y_rvalid;
  endproperty
  a_y_needs_mac: assert property (p_y_needs_mac)
    else $error("Y read answered outside a MAC operation");

  property p_unimpl_zero;
    x_req && !x_write && x_unimpl |-> ##2 x_rvalid && x_rdata == dsa_pkg::ZERO_WORD;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented address did not read zero");

  property p_y_cross_zero;
    y_take && y_bad |-> ##2 y_rvalid && y_rdata == dsa_pkg::ZERO_WORD;
  endproperty
  a_y_cross_zero: assert property (p_y_cross_zero)
    else $error("Y pointer outside Y space did not read zero");

  property p_byte_high_clear;
    x_req && !x_write && x_byte |-> ##2 x_rdata[DW-1:BW] == dsa_pkg::ZERO_BYTE;
  endproperty
  a_byte_high_clear: assert property (p_byte_high_clear)
    else $error("byte read left data in the high byte");

  property p_byte_lane;
    x_req && x_write && x_byte && !x_unimpl
      |-> wr_lane == (x_ea[SB] ? dsa_pkg::LANE_HI : dsa_pkg::LANE_LO);
  endproperty
  a_byte_lane: assert property (p_byte_lane)
    else $error("byte write strobed the wrong lane");

  property p_postinc_step;
    x_req && x_mode == dsa_pkg::AM_POSTINC |=> x_next_ptr == $past(x_src) + $past(x_step);
  endproperty
  a_postinc_step: assert property (p_postinc_step)
    else $error("post-increment stepped by the wrong amount");

  property p_misalign_trap;
    x_req && x_misalign |-> ##2 addr_error;
  endproperty
  a_misalign_trap: assert property (p_misalign_trap)
    else $error("misaligned word access raised no address error");

  property p_misalign_no_write;
    x_req && x_write && x_misalign |-> wr_lane == dsa_pkg::LANE_NONE;
  endproperty
  a_misalign_no_write: assert property (p_misalign_no_write)
    else $error("misaligned write reached memory");

  property p_byte_load_keeps;
    x_req && !x_write && x_byte |-> ##2 x_load_value[DW-1:BW] == $past(dest_old[DW-1:BW], 2);
  endproperty
  a_byte_load_keeps: assert property (p_byte_load_keeps)
    else $error("byte load changed the register high byte");

  property p_sign_extend;
    sign_extend_op |-> ##2 $signed(ext_value) == $signed($past(source_working_reg[BW-1:0], 2));
  endproperty
  a_sign_extend: assert property (p_sign_extend)
    else $error("sign extension result wrong");

  property p_error_cause;
    addr_error |-> $past((x_req && x_misalign) || (y_take && y_misalign), 2);
  endproperty
  a_error_cause: assert property (p_error_cause)
    else $error("address error without a misaligned access");

  c_misalign_write: cover property (x_req && x_write && x_misalign ##2 addr_error);
  c_byte_high_read: cover property (x_req && !x_write && x_byte && x_ea[SB] ##2 x_rvalid);
  c_dual_prefetch: cover property (x_req && y_take && !y_bad ##2 x_rvalid && y_rvalid);
endmodule
`default_nettype wire

/* File: rtl/dsa_pkg.sv */
// Constants and types shared by the data space access unit.
// Assumes one core clock and no software-visible registers.
`default_nettype none
package dsa_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  localparam int BYTE_W = 8;
  localparam int LANES = 2;
  localparam int NEAR_W = 13;
  localparam int RAM_AW = 7;
  localparam int RAM_WORDS = 128;
  localparam int BYTE_SEL_BIT = 0;
  localparam int WORD_LSB = 1;
  // Implemented memory and the fixed X/Y boundary
  localparam logic [15:0] RAM_TOP = 16'h0100;
  localparam logic [15:0] Y_BASE = 16'h0080;
  localparam logic [15:0] Y_LAST = 16'h00ff;
  localparam logic [15:0] NEAR_LAST = 16'h1fff;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [1:0] LANE_NONE = 2'h0;
  localparam logic [1:0] LANE_LO = 2'h1;
  localparam logic [1:0] LANE_HI = 2'h2;
  localparam logic [1:0] LANE_BOTH = 2'h3;
  typedef enum logic [2:0] {
    AM_INDIRECT, AM_POSTINC, AM_MODULO, AM_BITREV, AM_NEAR, AM_ABS16
  } addr_mode_e;
endpackage
`default_nettype wire

/* File: rtl/data_ram.sv */
// Byte-laned data memory: one write port, X and Y read ports.
// Assumes addresses are word indices; read data is registered.
`default_nettype none
module data_ram (
  input wire logic clock,
  input wire logic rst,
  input wire logic [dsa_pkg::LANES-1:0] wr_lane,
  input wire logic [dsa_pkg::RAM_AW-1:0] wr_addr,
  input wire logic [dsa_pkg::DATA_W-1:0] wr_data,
  input wire logic [dsa_pkg::RAM_AW-1:0] x_addr,
  input wire logic [dsa_pkg::RAM_AW-1:0] y_addr,
  output logic [dsa_pkg::DATA_W-1:0] x_data,
  output logic [dsa_pkg::DATA_W-1:0] y_data
);
  localparam int BW = dsa_pkg::BYTE_W;

  // Shared word decode, one write strobe per byte lane
  for (genvar lane = 0; lane < dsa_pkg::LANES; lane++) begin : g_lane
    logic [BW-1:0] cells [dsa_pkg::RAM_WORDS];
    logic [BW-1:0] x_q;
    logic [BW-1:0] y_q;
    always_ff @(posedge clock) begin
      if (wr_lane[lane]) begin
        cells[wr_addr] <= wr_data[lane*BW +: BW];
      end
    end
    // Same-cycle read of a written word returns the old value
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        x_q <= dsa_pkg::ZERO_BYTE;
        y_q <= dsa_pkg::ZERO_BYTE;
      end else begin
        x_q <= cells[x_addr];
        y_q <= cells[y_addr];
      end
    end
    assign x_data[lane*BW +: BW] = x_q;
    assign y_data[lane*BW +: BW] = y_q;
  end
endmodule
`default_nettype wire

/* File: rtl/load_format.sv */
// Byte selection, register byte merge and sign/zero extension.
// Purely combinational; the caller registers the results.
`default_nettype none
module load_format (
  input wire logic [dsa_pkg::DATA_W-1:0] word,
  input wire logic byte_hi,
  input wire logic byte_op,
  input wire logic zeroed,
  input wire logic [dsa_pkg::DATA_W-1:0] dest_old,
  input wire logic [dsa_pkg::DATA_W-1:0] source_working_reg,
  input wire logic sign_extend_op,
  input wire logic zero_extend_op,
  output logic [dsa_pkg::DATA_W-1:0] read_value,
  output logic [dsa_pkg::DATA_W-1:0] load_value,
  output logic [dsa_pkg::DATA_W-1:0] ext_value
);
  localparam int BW = dsa_pkg::BYTE_W;
  localparam int DW = dsa_pkg::DATA_W;
  logic [BW-1:0] picked;

  always_comb begin
    picked = byte_hi ? word[DW-1:BW] : word[BW-1:0];
    if (zeroed) begin
      picked = dsa_pkg::ZERO_BYTE;
    end
    read_value = zeroed ? dsa_pkg::ZERO_WORD : word;
    if (byte_op) begin
      read_value = {dsa_pkg::ZERO_BYTE, picked};
    end
    load_value = byte_op ? {dest_old[DW-1:BW], picked} : read_value;
    ext_value = source_working_reg;
    if (sign_extend_op) begin
      ext_value = {{BW{source_working_reg[BW-1]}}, source_working_reg[BW-1:0]};
    end else if (zero_extend_op) begin
      ext_value = {dsa_pkg::ZERO_BYTE, source_working_reg[BW-1:0]};
    end
  end
endmodule
`default_nettype wire

/* File: verif/core_model.sv */
// Core-side stand-in: the destination working register of a load.
// Assumes x_load_value is only meaningful while x_rvalid pulses.
`default_nettype none
module core_model #(
  parameter logic [15:0] INIT = 16'hc3c3
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic load_en,
  input wire logic x_rvalid,
  input wire logic [15:0] x_load_value,
  output logic [15:0] dest_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dest_reg <= INIT;
    end else if (load_en && x_rvalid) begin
      dest_reg <= x_load_value;
    end
  end
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the data space access unit.
// Assumes answers within four cycles of the request edge.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic wr;
    logic by;
    dsa_pkg::addr_mode_e md;
    logic [15:0] ea;
    logic [15:0] wd;
    logic [15:0] rd;
    logic err;
    logic [15:0] ptr;
  } row_s;
  localparam dsa_pkg::addr_mode_e pi = dsa_pkg::AM_POSTINC;
  localparam dsa_pkg::addr_mode_e br = dsa_pkg::AM_BITREV;
  localparam dsa_pkg::addr_mode_e mo = dsa_pkg::AM_MODULO;
  localparam dsa_pkg::addr_mode_e nr = dsa_pkg::AM_NEAR;
  localparam dsa_pkg::addr_mode_e ab = dsa_pkg::AM_ABS16;
  localparam dsa_pkg::addr_mode_e ix = dsa_pkg::AM_INDIRECT;
  localparam int n_rows = 22;
  row_s rows [n_rows] = '{
    '{1'b1,1'b0,pi,16'h0010,16'h1234,16'h0000,1'b0,16'h0012},
    '{1'b0,1'b0,pi,16'h0010,16'h0000,16'h1234,1'b0,16'h0012},
    '{1'b1,1'b1,pi,16'h0011,16'h00ab,16'h0000,1'b0,16'h0012},
    '{1'b0,1'b0,pi,16'h0010,16'h0000,16'hab34,1'b0,16'h0012},
    '{1'b0,1'b1,pi,16'h0011,16'h0000,16'h00ab,1'b0,16'h0012},
    '{1'b0,1'b1,pi,16'h0010,16'h0000,16'h0034,1'b0,16'h0011},
    '{1'b1,1'b0,pi,16'h0090,16'h5a5a,16'h0000,1'b0,16'h0092},
    '{1'b0,1'b0,pi,16'h0090,16'h0000,16'h5a5a,1'b0,16'h0092},
    '{1'b0,1'b0,pi,16'h0200,16'h0000,16'h0000,1'b0,16'h0202},
    '{1'b1,1'b0,pi,16'h0200,16'h1111,16'h0000,1'b0,16'h0202},
    '{1'b1,1'b0,pi,16'h0011,16'hffff,16'h0000,1'b1,16'h0013},
    '{1'b0,1'b0,pi,16'h0010,16'h0000,16'hab34,1'b0,16'h0012},
    '{1'b0,1'b0,pi,16'h0011,16'h0000,16'hab34,1'b1,16'h0013},
    '{1'b1,1'b0,br,16'h0010,16'hab34,16'h0000,1'b0,16'h0018},
    '{1'b0,1'b0,br,16'h0010,16'h0000,16'hab34,1'b0,16'h0012},
    '{1'b0,1'b0,mo,16'h0090,16'h0000,16'h5a5a,1'b0,16'h0080},
    '{1'b0,1'b0,nr,16'he010,16'h0000,16'hab34,1'b0,16'h0000},
    '{1'b0,1'b0,ab,16'h0090,16'h0000,16'h5a5a,1'b0,16'h0000},
    '{1'b0,1'b0,ix,16'h0010,16'h0000,16'hab34,1'b0,16'h0010},
    '{1'b1,1'b0,pi,16'h0020,16'h1234,16'h0000,1'b0,16'h0022},
    '{1'b1,1'b1,pi,16'h0020,16'h00c1,16'h0000,1'b0,16'h0021},
    '{1'b0,1'b0,pi,16'h0020,16'h0000,16'h12c1,1'b0,16'h0022}};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic mac_op, x_req, x_write, x_byte, x_acc_wb, x_ptr_pick, y_req, y_ptr_pick;
  logic sign_extend_op, zero_extend_op, load_en, got_x, got_y;
  dsa_pkg::addr_mode_e x_mode, y_mode;
  logic [15:0] x_base, x_direct, x_wdata, x_pointer_a, x_pointer_b, y_pointer_a, y_pointer_b;
  logic [15:0] mod_start, mod_end, bitrev_step, source_working_reg, dest_reg, xd, xl, yd;
  logic x_rvalid, y_rvalid, addr_error;
  logic [15:0] x_rdata, x_load_value, y_rdata, x_next_ptr, y_next_ptr, ext_value;
  logic [2:0] err_cnt;
  int n_fail = 0;
  int n_compared = 0;

  always #5 clock = ~clock;

  dual_data_space_access dual_data_space_access_inst (
    .clock, .rst, .mac_op, .x_req, .x_write, .x_byte, .x_acc_wb, .x_mode, .x_base,
    .x_direct, .x_wdata, .x_ptr_pick, .x_pointer_a, .x_pointer_b, .y_req, .y_mode,
    .y_ptr_pick, .y_pointer_a, .y_pointer_b, .mod_start, .mod_end, .bitrev_step,
    .dest_old(dest_reg), .source_working_reg, .sign_extend_op, .zero_extend_op,
    .x_rvalid, .x_rdata, .x_load_value, .y_rvalid, .y_rdata, .x_next_ptr, .y_next_ptr,
    .ext_value, .addr_error);

  core_model core_model_inst (.clock, .rst, .load_en, .x_rvalid, .x_load_value, .dest_reg);

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One request edge, then four cycles to collect pulses and data
  task automatic run(input logic mac, input logic xq, input logic yq);
    mac_op = mac;
    x_req = xq;
    y_req = yq;
    @(negedge clock);
    x_req = 1'b0;
    y_req = 1'b0;
    got_x = 1'b0;
    got_y = 1'b0;
    err_cnt = 3'h0;
    repeat (4) begin
      @(negedge clock);
      if (x_rvalid === 1'b1) begin
        got_x = 1'b1;
        xd = x_rdata;
        xl = x_load_value;
      end
      if (y_rvalid === 1'b1) begin
        got_y = 1'b1;
        yd = y_rdata;
      end
      if (addr_error === 1'b1) err_cnt = err_cnt + 3'h1;
    end
    mac_op = 1'b0;
  endtask

  task automatic ext(input logic s, input logic z, input logic [15:0] src, input logic [15:0] e);
    sign_extend_op = s;
    zero_extend_op = z;
    source_working_reg = src;
    @(negedge clock);
    sign_extend_op = 1'b0;
    zero_extend_op = 1'b0;
    repeat (3) @(negedge clock);
    chk("ext_value", e, ext_value);
  endtask

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #20000;
    n_fail++;
    $display("watchdog expired");
    results();
  end

  initial begin
    {mac_op, x_req, x_write, x_byte, x_acc_wb, x_ptr_pick, y_req, y_ptr_pick} = 8'h00;
    {sign_extend_op, zero_extend_op, load_en} = 3'h0;
    x_mode = pi;
    y_mode = pi;
    {x_base, x_direct, x_wdata, x_pointer_a, x_pointer_b} = {5{16'h0000}};
    {y_pointer_a, y_pointer_b, source_working_reg} = {3{16'h0000}};
    mod_start = 16'h0080;
    mod_end = 16'h0090;
    bitrev_step = 16'h0008;
    repeat (5) @(negedge clock);
    chk("reset flags", 16'h0000, {13'h0, x_rvalid, y_rvalid, addr_error});
    chk("reset data", 16'h0000, x_rdata | y_rdata | x_load_value | x_next_ptr | ext_value);
    rst = 1'b0;
    $display("reset test done");
    for (int i = 0; i < n_rows; i++) begin
      x_write = rows[i].wr;
      x_byte = rows[i].by;
      x_mode = rows[i].md;
      x_base = rows[i].ea;
      x_direct = rows[i].ea;
      x_wdata = rows[i].wd;
      run(1'b0, 1'b1, 1'b0);
      chk("x_rvalid", {15'h0, ~rows[i].wr}, {15'h0, got_x});
      if (!rows[i].wr) begin
        chk("x_rdata", rows[i].rd, xd);
        chk("x_load_value", rows[i].by ? {8'hc3, rows[i].rd[7:0]} : rows[i].rd, xl);
      end
      chk("addr_error", {15'h0, rows[i].err}, {13'h0, err_cnt});
      if (rows[i].md != nr && rows[i].md != ab) begin
        chk("x_next_ptr", rows[i].ptr, x_next_ptr);
      end
    end
    $display("table test done");
    {x_write, x_byte} = 2'h0;
    x_mode = pi;
    {x_pointer_a, x_pointer_b, y_pointer_a, y_pointer_b} = {16'h0090, 16'h0010, 16'h0090, 16'h0010};
    run(1'b1, 1'b1, 1'b1);
    chk("mac x ptr in y", 16'h0000, xd);
    chk("mac y read", 16'h5a5a, yd);
    chk("y_next_ptr", 16'h0092, y_next_ptr);
    {x_ptr_pick, y_ptr_pick} = 2'h3;
    run(1'b1, 1'b1, 1'b1);
    chk("mac x read", 16'hab34, xd);
    chk("mac y ptr in x", 16'h0000, yd);
    run(1'b0, 1'b0, 1'b1);
    chk("y without mac", 16'h0000, {15'h0, got_y});
    {y_ptr_pick, y_pointer_a} = {1'b0, 16'h0091};
    run(1'b1, 1'b0, 1'b1);
    chk("y misaligned", 16'h0001, {13'h0, err_cnt});
    y_mode = mo;
    y_pointer_a = 16'h0090;
    run(1'b1, 1'b0, 1'b1);
    chk("y modulo wrap", 16'h0080, y_next_ptr);
    $display("mac test done");
    {x_write, x_acc_wb, x_base, x_wdata} = {2'h3, 16'h0092, 16'h7777};
    run(1'b1, 1'b1, 1'b0);
    {x_write, x_acc_wb, y_pointer_a} = {2'h0, 16'h0092};
    y_mode = pi;
    run(1'b1, 1'b0, 1'b1);
    chk("acc write back", 16'h7777, yd);
    {load_en, x_byte, x_base} = {2'h3, 16'h0011};
    run(1'b0, 1'b1, 1'b0);
    load_en = 1'b0;
    chk("byte load", 16'hc3ab, dest_reg);
    ext(1'b1, 1'b0, 16'h1280, 16'hff80);
    ext(1'b0, 1'b1, 16'h12f0, 16'h00f0);
    ext(1'b1, 1'b1, 16'h00f0, 16'hfff0);
    $display("load test done");
    rst = 1'b1;
    repeat (2) @(negedge clock);
    chk("mid reset", 16'h0000, x_next_ptr | y_next_ptr | ext_value | x_rdata);
    rst = 1'b0;
    {x_byte, x_base} = {1'b0, 16'h0010};
    run(1'b0, 1'b1, 1'b0);
    chk("read after reset", 16'hab34, xd);
    $display("second reset test done");
    results();
  end
endmodule
`default_nettype wire
